// ---- pkg/mbi_map.svh ----
`ifndef MBI_MAP_SVH
`define MBI_MAP_SVH

// clock rate in MHz
`define MBI_CLK_MHZ 40
// standard-mode quarter, one clock phase, about 5 us bit at 200 kHz
`define MBI_STD_QUARTER_NS 2500
`define MBI_STD_QUARTER_CYC ((`MBI_STD_QUARTER_NS * `MBI_CLK_MHZ + 999) / 1000)
// fast pulse timing, about 400 kHz bit rate
`define MBI_FAST_QUARTER_NS 1250
`define MBI_FAST_QUARTER_CYC ((`MBI_FAST_QUARTER_NS * `MBI_CLK_MHZ + 999) / 1000)
// clock stretch timeout, 17 ms
`define MBI_STRETCH_TMO_MS 17
`define MBI_STRETCH_TMO_CYC (`MBI_STRETCH_TMO_MS * `MBI_CLK_MHZ * 1000)
// physical buses and logical numbering
`define MBI_NUM_PHYS 4
`define MBI_BUS_RST 4'h1
`define MBI_FAST_FIRST 4'h5
`define MBI_FAST_LAST 4'h8
// spi chip select choices on bus four pins
`define MBI_CS_CLK_PIN 2'h2
`define MBI_CS_DATA_PIN 2'h3
// direction bit of the address byte
`define MBI_DIR_BIT 0
`define MBI_TIMING_RST 8'h00
`define MBI_FIFO_DEPTH 8

`endif

// ---- pkg/mbi_pkg.sv ----
package mbi_pkg;

  typedef enum logic [2:0] {
    MBI_OP_START,
    MBI_OP_STOP,
    MBI_OP_WRITE,
    MBI_OP_READ,
    MBI_OP_SELECT
  } mbi_op_e;

  typedef struct packed {
    mbi_op_e op;
    logic [7:0] data;
    logic nack_last;
  } mbi_cmd_s;

  typedef struct packed {
    logic busy;
    logic started;
    logic read_dir;
    logic nack;
    logic timeout;
    logic [3:0] bus;
  } mbi_status_s;

  typedef enum logic [3:0] {
    MBI_IDLE,
    MBI_S_REL,
    MBI_S_HI,
    MBI_S_LO,
    MBI_S_END,
    MBI_P_LO,
    MBI_P_HI,
    MBI_P_END,
    MBI_B_LO,
    MBI_B_HI
  } mbi_st_e;

endpackage

// ---- hw/mbi_fifo.sv ----
`timescale 1ns/10ps
module mbi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("fifo depth must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic full_q, full_d, empty_q, empty_d;
  logic push, pop;

  assign in_ready = !full_q;
  assign out_valid = !empty_q;
  assign out_data = mem[rd_q];

  always_comb begin
    push = in_valid && !full_q;
    pop = out_ready && !empty_q;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    full_d = full_q;
    empty_d = empty_q;
    if (push && !pop) begin
      full_d = (wr_d == rd_q);
      empty_d = 1'b0;
    end else if (pop && !push) begin
      empty_d = (rd_d == wr_q);
      full_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      full_q <= full_d;
      empty_q <= empty_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule

// ---- hw/mbi_engine.sv ----
// Overview of operation
// - four physical buses, numbered one to four
// - only the selected bus pins are driven, plus bus four pins as spi selects
// - stop on active bus before switching bus
// - numbers above four are logical bus variants
// - lines are only pulled low or released
// - spi mode shifts bytes over selected bus
// - default timing gives about 200 kHz clock, above 100 kHz standard mode
// - timing byte lengthens each bit phase
// - slave clock stretch honoured on every bit
// - clock tested at bit, start, stop high phase
// - stretch wait abandoned after about 17 ms
// - stretch timeout sets a status flag
// - fast pulse timing available on logical buses five to eight
// - fast timing gives about 400 kHz clock
// - sole master, no arbitration checking
// - bus four pins double as spi selects
// - select accepts 1 to F, stops first
// - address bit zero picks read or write
`timescale 1ns/10ps
`include "mbi_map.svh"
module mbi_engine import mbi_pkg::*; #(
  parameter int STRETCH_TMO_CYC = `MBI_STRETCH_TMO_CYC,
  parameter int FIFO_DEPTH = `MBI_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command stream
  input wire logic cmd_valid,
  input wire mbi_cmd_s cmd,
  output logic cmd_ready,
  // read data
  output logic rd_valid,
  output logic [7:0] rd_data,
  // configuration
  input wire logic spi_mode,
  input wire logic [1:0] spi_cs_sel,
  input wire logic [7:0] bus_bit_timing_byte,
  input wire logic clr_timeout,
  // status
  output mbi_status_s status,
  // bus pins, open drain
  input wire logic [3:0] scl_i,
  output logic [3:0] scl_o,
  output logic [3:0] scl_oe,
  input wire logic [3:0] sda_i,
  output logic [3:0] sda_o,
  output logic [3:0] sda_oe
);
  localparam int CW = 20;

  initial begin
    if (STRETCH_TMO_CYC < 2 || STRETCH_TMO_CYC >= (1 << CW)) begin
      $error("stretch timeout out of counter range");
    end
  end

  function automatic logic [1:0] phys_of(input logic [3:0] bus);
    phys_of = 2'(bus - 4'h1);
  endfunction

  function automatic logic [CW-1:0] quarter(input logic [3:0] bus, input logic [7:0] tb);
    logic fast;
    fast = (bus >= `MBI_FAST_FIRST) && (bus <= `MBI_FAST_LAST);
    if (fast) begin
      quarter = CW'(`MBI_FAST_QUARTER_CYC) + CW'(tb);
    end else begin
      quarter = CW'(`MBI_STD_QUARTER_CYC) + CW'(tb);
    end
  endfunction

  // fifo in the command path
  mbi_cmd_s f_data;
  logic f_valid, f_pop;

  mbi_fifo #(.WIDTH($bits(mbi_cmd_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(cmd_valid),
    .in_data(cmd),
    .in_ready(cmd_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_pop)
  );

  // pin synchronisers
  logic [3:0] scl_m_q, scl_s_q, sda_m_q, sda_s_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_m_q <= 4'hf;
      scl_s_q <= 4'hf;
      sda_m_q <= 4'hf;
      sda_s_q <= 4'hf;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
    end
  end

  mbi_st_e st_q, st_d;
  mbi_cmd_s cur_q, cur_d;
  logic [CW-1:0] tmr_q, tmr_d, wait_q, wait_d;
  logic [3:0] bit_q, bit_d, bus_q, bus_d, pend_q, pend_d;
  logic [7:0] sh_q, sh_d, rdat_q, rdat_d;
  logic hi_q, hi_d, sel_q, sel_d, started_q, started_d, first_q, first_d;
  logic dir_q, dir_d, nack_q, nack_d, tmo_q, tmo_d, rv_q, rv_d;
  logic lo_scl_q, lo_scl_d, lo_sda_q, lo_sda_d, busy_q, busy_d;
  logic [3:0] scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic scl_now, sda_now, tdone, wait_ok, wait_tmo, last_bit, in_byte;
  logic [CW-1:0] q_cyc;

  always_comb begin
    st_d = st_q;
    cur_d = cur_q;
    tmr_d = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
    wait_d = wait_q;
    bit_d = bit_q;
    bus_d = bus_q;
    pend_d = pend_q;
    sh_d = sh_q;
    rdat_d = rdat_q;
    hi_d = hi_q;
    sel_d = sel_q;
    started_d = started_q;
    first_d = first_q;
    dir_d = dir_q;
    nack_d = nack_q;
    tmo_d = tmo_q;
    rv_d = 1'b0;
    lo_scl_d = lo_scl_q;
    lo_sda_d = lo_sda_q;
    f_pop = 1'b0;
    scl_now = scl_s_q[phys_of(bus_q)];
    sda_now = sda_s_q[phys_of(bus_q)];
    q_cyc = quarter(bus_q, bus_bit_timing_byte);
    tdone = (tmr_q == '0);
    last_bit = spi_mode ? (bit_q == 4'h7) : (bit_q == 4'h8);
    // released clock must read high before the phase is timed
    wait_ok = 1'b0;
    wait_tmo = 1'b0;
    if (!hi_q && (st_q == MBI_S_HI || st_q == MBI_P_HI || st_q == MBI_B_HI)) begin
      if (scl_now) begin
        hi_d = 1'b1;
        wait_d = '0;
        tmr_d = q_cyc;
      end else if (wait_q == CW'(STRETCH_TMO_CYC - 1)) begin
        wait_tmo = 1'b1;
      end else begin
        wait_d = wait_q + 1'b1;
      end
    end
    wait_ok = hi_q && tdone;
    unique case (st_q)
      MBI_IDLE: begin
        if (f_valid) begin
          f_pop = 1'b1;
          cur_d = f_data;
          tmr_d = q_cyc;
          hi_d = 1'b0;
          bit_d = '0;
          unique case (f_data.op)
            MBI_OP_START: begin
              if (!spi_mode) begin
                st_d = MBI_S_REL;
              end
            end
            MBI_OP_STOP: begin
              if (started_q) begin
                st_d = MBI_P_LO;
              end
            end
            MBI_OP_WRITE: begin
              // after a read address only reads proceed
              if (spi_mode || first_q || !dir_q) begin
                sh_d = f_data.data;
                st_d = MBI_B_LO;
                if (first_q) begin
                  dir_d = f_data.data[`MBI_DIR_BIT];
                  first_d = 1'b0;
                end
              end
            end
            MBI_OP_READ: begin
              if (spi_mode || (started_q && !first_q && dir_q)) begin
                sh_d = 8'hff;
                st_d = MBI_B_LO;
              end
            end
            MBI_OP_SELECT: begin
              if (f_data.data[3:0] != 4'h0) begin
                if (started_q) begin
                  pend_d = f_data.data[3:0];
                  sel_d = 1'b1;
                  st_d = MBI_P_LO;
                end else begin
                  bus_d = f_data.data[3:0];
                end
              end
            end
            default: begin
            end
          endcase
        end
      end
      MBI_S_REL: begin
        lo_sda_d = 1'b0;
        if (tdone) begin
          st_d = MBI_S_HI;
        end
      end
      MBI_S_HI: begin
        lo_scl_d = 1'b0;
        if (wait_ok) begin
          lo_sda_d = 1'b1;
          tmr_d = q_cyc;
          st_d = MBI_S_LO;
        end
      end
      MBI_S_LO: begin
        if (tdone) begin
          lo_scl_d = 1'b1;
          tmr_d = q_cyc;
          st_d = MBI_S_END;
        end
      end
      MBI_S_END: begin
        if (tdone) begin
          started_d = 1'b1;
          first_d = 1'b1;
          st_d = MBI_IDLE;
        end
      end
      MBI_P_LO: begin
        lo_scl_d = 1'b1;
        lo_sda_d = 1'b1;
        if (tdone) begin
          hi_d = 1'b0;
          st_d = MBI_P_HI;
        end
      end
      MBI_P_HI: begin
        lo_scl_d = 1'b0;
        if (wait_ok) begin
          lo_sda_d = 1'b0;
          tmr_d = q_cyc;
          st_d = MBI_P_END;
        end
      end
      MBI_P_END: begin
        if (tdone) begin
          started_d = 1'b0;
          first_d = 1'b0;
          dir_d = 1'b0;
          if (sel_q) begin
            bus_d = pend_q;
            sel_d = 1'b0;
          end
          st_d = MBI_IDLE;
        end
      end
      MBI_B_LO: begin
        lo_scl_d = 1'b1;
        if (bit_q[3]) begin
          lo_sda_d = (cur_q.op == MBI_OP_READ) && !cur_q.nack_last;
        end else begin
          lo_sda_d = !sh_q[7];
        end
        if (tdone) begin
          hi_d = 1'b0;
          st_d = MBI_B_HI;
        end
      end
      MBI_B_HI: begin
        lo_scl_d = 1'b0;
        if (wait_ok) begin
          tmr_d = q_cyc;
          if (bit_q[3]) begin
            nack_d = sda_now;
          end else begin
            sh_d = {sh_q[6:0], sda_now};
          end
          if (last_bit) begin
            if (cur_q.op == MBI_OP_READ) begin
              rdat_d = spi_mode ? {sh_q[6:0], sda_now} : sh_q;
              rv_d = 1'b1;
            end
            // spi leaves both lines released between bytes
            lo_scl_d = !spi_mode;
            lo_sda_d = lo_sda_q && !spi_mode;
            st_d = MBI_S_END;
          end else begin
            bit_d = bit_q + 1'b1;
            st_d = MBI_B_LO;
          end
        end
      end
      default: begin
        st_d = MBI_IDLE;
      end
    endcase
    if (st_q == MBI_S_END && last_bit && tdone) begin
      // byte end reuses the hold state without restarting
      started_d = started_q;
      first_d = first_q;
    end
    if (wait_tmo) begin
      lo_scl_d = 1'b0;
      lo_sda_d = 1'b0;
      started_d = 1'b0;
      first_d = 1'b0;
      wait_d = '0;
      if (sel_q) begin
        bus_d = pend_q;
        sel_d = 1'b0;
      end
      st_d = MBI_IDLE;
    end
    if (clr_timeout) begin
      tmo_d = 1'b0;
    end
    if (wait_tmo) begin
      tmo_d = 1'b1;
    end
    busy_d = (st_d != MBI_IDLE);
    // pins of the active bus only, plus spi selects
    scl_oe_d = 4'h0;
    sda_oe_d = 4'h0;
    scl_oe_d[phys_of(bus_q)] = lo_scl_d;
    sda_oe_d[phys_of(bus_q)] = lo_sda_d;
    in_byte = spi_mode && (st_d == MBI_B_LO || st_d == MBI_B_HI);
    if (in_byte && spi_cs_sel == `MBI_CS_CLK_PIN) begin
      scl_oe_d[`MBI_NUM_PHYS-1] = 1'b1;
    end
    if (in_byte && spi_cs_sel == `MBI_CS_DATA_PIN) begin
      sda_oe_d[`MBI_NUM_PHYS-1] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= MBI_IDLE;
      cur_q <= '0;
      tmr_q <= '0;
      wait_q <= '0;
      bit_q <= '0;
      bus_q <= `MBI_BUS_RST;
      pend_q <= `MBI_BUS_RST;
      sh_q <= '0;
      rdat_q <= '0;
      hi_q <= 1'b0;
      sel_q <= 1'b0;
      started_q <= 1'b0;
      first_q <= 1'b0;
      dir_q <= 1'b0;
      nack_q <= 1'b0;
      tmo_q <= 1'b0;
      rv_q <= 1'b0;
      lo_scl_q <= 1'b0;
      lo_sda_q <= 1'b0;
      busy_q <= 1'b0;
      scl_oe_q <= 4'h0;
      sda_oe_q <= 4'h0;
    end else begin
      st_q <= st_d;
      cur_q <= cur_d;
      tmr_q <= tmr_d;
      wait_q <= wait_d;
      bit_q <= bit_d;
      bus_q <= bus_d;
      pend_q <= pend_d;
      sh_q <= sh_d;
      rdat_q <= rdat_d;
      hi_q <= hi_d;
      sel_q <= sel_d;
      started_q <= started_d;
      first_q <= first_d;
      dir_q <= dir_d;
      nack_q <= nack_d;
      tmo_q <= tmo_d;
      rv_q <= rv_d;
      lo_scl_q <= lo_scl_d;
      lo_sda_q <= lo_sda_d;
      busy_q <= busy_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  assign rd_valid = rv_q;
  assign rd_data = rdat_q;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign scl_o = 4'h0;
  assign sda_o = 4'h0;
  assign status = '{busy: busy_q, started: started_q, read_dir: dir_q,
                    nack: nack_q, timeout: tmo_q, bus: bus_q};
endmodule

// ---- test/mbi_engine_asserts.sv ----
`timescale 1ns/10ps
`include "mbi_map.svh"
module mbi_engine_asserts import mbi_pkg::*; #(
  parameter int STRETCH_TMO_CYC = 200
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command and read data
  input wire logic cmd_valid,
  input wire mbi_cmd_s cmd,
  input wire logic cmd_ready,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  // configuration and status
  input wire logic spi_mode,
  input wire logic [1:0] spi_cs_sel,
  input wire logic [7:0] bus_bit_timing_byte,
  input wire logic clr_timeout,
  input wire mbi_status_s status,
  // bus pins
  input wire logic [3:0] scl_i,
  input wire logic [3:0] scl_o,
  input wire logic [3:0] scl_oe,
  input wire logic [3:0] sda_i,
  input wire logic [3:0] sda_o,
  input wire logic [3:0] sda_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [31:0] low_q, low_d, hold_q, hold_d;
  logic fast;
  assign fast = status.bus >= `MBI_FAST_FIRST && status.bus <= `MBI_FAST_LAST;
  // clock held low by us, and by a slave while we wait
  always_comb begin
    low_d = (|scl_oe) ? low_q + 32'h1 : 32'h0;
    hold_d = (status.busy && |(~scl_i & ~scl_oe)) ? hold_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_q <= 32'h0;
      hold_q <= 32'h0;
    end else begin
      low_q <= low_d;
      hold_q <= hold_d;
    end
  end
  sequence s_scl_release;
    $fell(|scl_oe) && !spi_mode;
  endsequence
  sequence s_tmo;
    $rose(status.timeout);
  endsequence
  property p_open_drain;
    scl_o == 4'h0 && sda_o == 4'h0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pin driven high");
  property p_one_bus;
    !spi_mode |-> $onehot0(scl_oe | sda_oe);
  endproperty
  a_one_bus: assert property (p_one_bus)
    else $error("two buses driven");
  property p_quarter_min;
    s_scl_release |-> low_q >= (fast ? 32'h32 : 32'h64) + bus_bit_timing_byte;
  endproperty
  a_quarter_min: assert property (p_quarter_min)
    else $error("clock low phase too short");
  property p_tmo_late;
    hold_q <= STRETCH_TMO_CYC + 8;
  endproperty
  a_tmo_late: assert property (p_tmo_late)
    else $error("stretch wait not abandoned");
  property p_tmo_early;
    s_tmo |-> hold_q >= STRETCH_TMO_CYC - 4;
  endproperty
  a_tmo_early: assert property (p_tmo_early)
    else $error("timeout flagged too early");
  property p_tmo_release;
    s_tmo |-> ##[0:2] (scl_oe == 4'h0 && sda_oe == 4'h0 && !status.started);
  endproperty
  a_tmo_release: assert property (p_tmo_release)
    else $error("lines kept after timeout");
  property p_bus_change;
    $changed(status.bus) |-> !status.started;
  endproperty
  a_bus_change: assert property (p_bus_change)
    else $error("bus changed while started");
  property p_idle_free;
    (!status.busy && !status.started) [*2] |-> scl_oe == 4'h0 && sda_oe == 4'h0;
  endproperty
  a_idle_free: assert property (p_idle_free)
    else $error("lines held while stopped");
  property p_rd_dir;
    rd_valid |-> status.read_dir || spi_mode;
  endproperty
  a_rd_dir: assert property (p_rd_dir)
    else $error("read data without read direction");
endmodule

// ---- test/mbi_slave_model.sv ----
`timescale 1ns/10ps
module mbi_slave_model (
  // clock
  input wire logic clk,
  // pins of the engine
  input wire logic [3:0] scl_oe,
  input wire logic [3:0] sda_oe,
  output logic [3:0] scl_i,
  output logic [3:0] sda_i,
  // control and capture
  input wire logic [1:0] phys,
  input wire logic [7:0] rd_byte,
  input wire logic [15:0] stretch,
  output logic [7:0] got = 8'h00,
  output logic [7:0] stops = 8'h00
);
  logic scl_low = 1'b0, sda_low = 1'b0, rd = 1'b0, first = 1'b0, nack = 1'b1;
  logic scl_p = 1'b1, sda_p = 1'b1, scl, sda;
  logic [7:0] sh = 8'h00;
  int n = 0, hold = 0;
  // pull-ups on every line, slave pulls only its own bus
  always_comb begin
    scl_i = ~scl_oe;
    sda_i = ~sda_oe;
    scl_i[phys] = ~(scl_oe[phys] | scl_low);
    sda_i[phys] = ~(sda_oe[phys] | sda_low);
  end
  assign scl = scl_i[phys];
  assign sda = sda_i[phys];
  always @(posedge clk) begin
    scl_p <= scl;
    sda_p <= sda;
    if (hold > 0) hold <= hold - 1;
    else scl_low <= 1'b0;
    if (scl && scl_p && sda_p && !sda) begin
      n <= 0;
      first <= 1'b1;
      rd <= 1'b0;
      nack <= 1'b0;
    end else if (scl && scl_p && !sda_p && sda) begin
      stops <= stops + 8'h01;
      rd <= 1'b0;
      nack <= 1'b1;
    end else if (scl && !scl_p) begin
      n <= n + 1;
      if (n < 8) sh <= {sh[6:0], sda};
      if (n == 8 && rd) nack <= sda;
    end else if (!scl && scl_p) begin
      if (n == 8) sda_low <= !rd;
      else if (n == 9) begin
        n <= 0;
        first <= 1'b0;
        if (!rd) got <= sh;
        rd <= rd | (first & sh[0]);
        sda_low <= (rd | (first & sh[0])) & !nack & !rd_byte[7];
        if (stretch != 16'h0) begin
          scl_low <= 1'b1;
          hold <= int'(stretch);
        end
      end else if (rd && !nack) sda_low <= !rd_byte[3'(7 - n)];
    end
  end
endmodule

// ---- test/multi_bus_i2c_master_engine_tb_top.sv ----
`timescale 1ns/10ps
`include "mbi_map.svh"
module multi_bus_i2c_master_engine_tb_top import mbi_pkg::*;;
  localparam int TMO = 200;
  logic clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, cmd_ready, rd_valid;
  logic spi_mode = 1'b0, clr_timeout = 1'b0, dir_seen = 1'b0;
  logic [1:0] spi_cs_sel = 2'h0, phys = 2'h1;
  logic [7:0] rd_data, bus_bit_timing_byte = 8'h00, rd_byte = 8'h00, got, stops, a, d;
  logic [15:0] stretch = 16'h0;
  logic [3:0] scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe;
  mbi_cmd_s cmd = '0;
  mbi_status_s status;
  int seed = 32'h32a6aa5f, bad_count = 0, compares = 0, cyc = 0, cs_cnt = 0, k, s;
  mbi_engine #(.STRETCH_TMO_CYC(TMO)) dut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .spi_mode(spi_mode), .spi_cs_sel(spi_cs_sel), .bus_bit_timing_byte(bus_bit_timing_byte),
    .clr_timeout(clr_timeout), .status(status), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
  mbi_slave_model u_slave (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_i(scl_i),
    .sda_i(sda_i), .phys(phys), .rd_byte(rd_byte), .stretch(stretch), .got(got),
    .stops(stops));
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    cs_cnt <= cs_cnt + ((spi_mode && (spi_cs_sel == 2'h2 ? scl_oe[3] : sda_oe[3])) ? 1 : 0);
    if (cyc == 100000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input mbi_op_e op, input logic [7:0] dat, input logic nl);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, data: dat, nack_last: nl};
    do @(posedge clk); while (cmd_ready !== 1'b1);
  endtask
  task automatic settle();
    int quiet;
    quiet = 0;
    cmd_valid <= 1'b0;
    for (int i = 0; i < 60000 && quiet < 8; i++) begin
      @(posedge clk);
      quiet = (status.busy === 1'b0) ? quiet + 1 : 0;
    end
  endtask
  task automatic xfer(input logic [3:0] bus, input logic [7:0] adr, input logic [7:0] dat);
    phys <= 2'(bus - 4'h1);
    send(MBI_OP_SELECT, {4'h0, bus}, 1'b0);
    send(MBI_OP_START, 8'h00, 1'b0);
    send(MBI_OP_WRITE, adr, 1'b0);
    send(adr[0] ? MBI_OP_READ : MBI_OP_WRITE, dat, 1'b1);
    settle();
    // direction is cleared by the stop, so take it while started
    dir_seen = status.read_dir;
    send(MBI_OP_STOP, 8'h00, 1'b0);
    settle();
  endtask
  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("ready", 32'h1, cmd_ready);
    chk("status", 32'h1, status);
    chk("oe", 32'h0, {scl_oe, sda_oe});
    $display("test reset done");
    stretch <= 16'h1e;
    a = 8'($random(seed)) & 8'hfe;
    d = 8'($random(seed));
    xfer(4'h2, a, d);
    chk("write byte", d, got);
    chk("bus", 32'h2, status.bus);
    chk("nack", 32'h0, status.nack);
    chk("dir", 32'h0, dir_seen);
    $display("test write done");
    stretch <= 16'h0;
    bus_bit_timing_byte <= 8'($random(seed)) & 8'h03;
    rd_byte <= 8'($random(seed));
    xfer(4'h3, a | 8'h01, 8'h00);
    chk("read byte", rd_byte, rd_data);
    chk("dir", 32'h1, dir_seen);
    $display("test read done");
    for (int n = 5; n <= 8; n++) begin
      d = 8'($random(seed));
      xfer(4'(n), 8'h40, d);
      chk("fast byte", d, got);
    end
    $display("test fast done");
    for (int n = 0; n < 16; n++) begin
      send(MBI_OP_SELECT, 8'(n), 1'b0);
      settle();
      chk("select", n == 0 ? 32'h8 : 32'(n), status.bus);
    end
    $display("test select done");
    phys <= 2'h0;
    send(MBI_OP_SELECT, 8'h01, 1'b0);
    send(MBI_OP_START, 8'h00, 1'b0);
    s = int'(stops);
    send(MBI_OP_SELECT, 8'h04, 1'b0);
    settle();
    chk("stop first", 32'(s + 1), stops);
    chk("bus", 32'h4, status.bus);
    $display("test switch done");
    phys <= 2'h3;
    stretch <= 16'h3e8;
    send(MBI_OP_START, 8'h00, 1'b0);
    send(MBI_OP_WRITE, 8'h40, 1'b0);
    send(MBI_OP_WRITE, 8'h11, 1'b0);
    settle();
    chk("timeout", 32'h1, status.timeout);
    chk("started", 32'h0, status.started);
    chk("released", 32'h0, {scl_oe, sda_oe});
    clr_timeout <= 1'b1;
    stretch <= 16'h0;
    @(posedge clk);
    clr_timeout <= 1'b0;
    for (int i = 0; i < 2000 && scl_i[3] !== 1'b1; i++) @(posedge clk);
    chk("cleared", 32'h0, status.timeout);
    $display("test timeout done");
    phys <= 2'h0;
    send(MBI_OP_SELECT, 8'h05, 1'b0);
    settle();
    cmd_valid <= 1'b1;
    cmd <= '{op: MBI_OP_START, data: 8'h00, nack_last: 1'b0};
    @(posedge clk);
    cmd <= '{op: MBI_OP_WRITE, data: 8'h5a, nack_last: 1'b0};
    k = 0;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      if (cmd_ready === 1'b1) k++;
    end
    chk("fill", `MBI_FIFO_DEPTH, k);
    chk("full", 32'h0, cmd_ready);
    @(posedge clk);
    stretch <= 16'h14;
    send(MBI_OP_STOP, 8'h00, 1'b0);
    settle();
    chk("drain byte", 32'h5a, got);
    chk("empty", 32'h1, cmd_ready);
    $display("test fifo done");
    stretch <= 16'h0;
    spi_mode <= 1'b1;
    send(MBI_OP_SELECT, 8'h02, 1'b0);
    for (int c = 2; c < 4; c++) begin
      spi_cs_sel <= 2'(c);
      s = cs_cnt;
      send(MBI_OP_WRITE, 8'($random(seed)), 1'b0);
      send(MBI_OP_READ, 8'h00, 1'b0);
      settle();
      chk("spi select", 32'h1, (cs_cnt > s) ? 32'h1 : 32'h0);
      chk("spi read", 32'hff, rd_data);
    end
    spi_mode <= 1'b0;
    $display("test spi done");
    final_report();
  end
endmodule
bind mbi_engine mbi_engine_asserts #(.STRETCH_TMO_CYC(STRETCH_TMO_CYC)) u_chk (
  .clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
  .rd_valid(rd_valid), .rd_data(rd_data), .spi_mode(spi_mode), .spi_cs_sel(spi_cs_sel),
  .bus_bit_timing_byte(bus_bit_timing_byte), .clr_timeout(clr_timeout), .status(status),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe));
